// File: core/sgbs_defines.vh
`ifndef SGBS_DEFINES_VH
`define SGBS_DEFINES_VH

// ----------------------------------------
// Command codes after decode
// ----------------------------------------
`define SGBS_CMD_W        4
`define SGBS_CMD_DESEL    4'h0
`define SGBS_CMD_NOP      4'h1
`define SGBS_CMD_ACT      4'h2
`define SGBS_CMD_RD       4'h3
`define SGBS_CMD_WR       4'h4
`define SGBS_CMD_PRE      4'h5
`define SGBS_CMD_REF      4'h6
`define SGBS_CMD_MRS      4'h7
`define SGBS_CMD_RSV      4'h8

// ----------------------------------------
// Per-bank state codes (one-hot)
// ----------------------------------------
`define SGBS_ST_W         8
`define SGBS_ST_IDLE      8'h01
`define SGBS_ST_ACTG      8'h02
`define SGBS_ST_ACTV      8'h04
`define SGBS_ST_READ      8'h08
`define SGBS_ST_WRITE     8'h10
`define SGBS_ST_PRE       8'h20
`define SGBS_ST_RDAP      8'h40
`define SGBS_ST_WRAP      8'h80

// ----------------------------------------
// Device-wide state codes (one-hot)
// ----------------------------------------
`define SGBS_DV_W         4
`define SGBS_DV_NORM      4'h1
`define SGBS_DV_REF       4'h2
`define SGBS_DV_MRS       4'h4
`define SGBS_DV_PALL      4'h8

// ----------------------------------------
// Write mask kinds
// ----------------------------------------
`define SGBS_WM_NONE      2'h0
`define SGBS_WM_SINGLE    2'h1
`define SGBS_WM_DOUBLE    2'h2

// ----------------------------------------
// Default timing counts in command clocks
// ----------------------------------------
`define SGBS_T_RP         4'h4
`define SGBS_T_RCD        4'h4
`define SGBS_T_RC         6'h10
`define SGBS_T_MRD        4'h4
`define SGBS_T_WR         4'h4
`define SGBS_T_BURST      4'h2

`endif

// File: core/sgbs_cmd_decode.v
`timescale 1ns/1ns
`include "sgbs_defines.vh"

// Command decode from strobe lines, also qualified by the clock enable history
module sgbs_cmd_decode (
    input  wire                    cs_n,
    input  wire                    ras_n,
    input  wire                    cas_n,
    input  wire                    we_n,
    input  wire                    cke_n,
    input  wire                    cke_n_prev,
    input  wire                    xs_done,
    output reg  [`SGBS_CMD_W-1:0]  cmd,
    output wire                    tables_on
);
    // Tables only hold with enable active on both edges and exit delay met
    assign tables_on = ~cke_n & ~cke_n_prev & xs_done;

    // ----------------------------------------
    // Strobe decode
    // ----------------------------------------
    always @* begin
        if (cs_n) begin
            cmd = `SGBS_CMD_DESEL;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'b111:  cmd = `SGBS_CMD_NOP;
                3'b011:  cmd = `SGBS_CMD_ACT;
                3'b101:  cmd = `SGBS_CMD_RD;
                3'b100:  cmd = `SGBS_CMD_WR;
                3'b010:  cmd = `SGBS_CMD_PRE;
                3'b001:  cmd = `SGBS_CMD_REF;
                3'b000:  cmd = `SGBS_CMD_MRS;
                default: cmd = `SGBS_CMD_RSV;
            endcase
        end
    end
endmodule

// File: core/sgbs_bank.v
`timescale 1ns/1ns
`include "sgbs_defines.vh"

// One bank's state machine with its own timer
module sgbs_bank #(
    parameter [3:0] T_RP    = `SGBS_T_RP,
    parameter [3:0] T_RCD   = `SGBS_T_RCD,
    parameter [3:0] T_WR    = `SGBS_T_WR,
    parameter [3:0] T_BURST = `SGBS_T_BURST
) (
    input  wire                    core_clk,
    input  wire                    arst_n,
    input  wire                    hit,
    input  wire [`SGBS_CMD_W-1:0]  cmd,
    input  wire                    auto_pre,
    input  wire                    force_idle,
    output reg  [`SGBS_ST_W-1:0]   state_q,
    output wire                    legal,
    output wire                    ap_pre_phase,
    output wire                    burst_busy
);
    localparam [3:0] ONE = 4'h1;

    reg  [3:0]              tmr_q;
    reg                     pre_ph_q;
    reg  [`SGBS_ST_W-1:0]   state_d;
    reg  [3:0]              tmr_d;
    reg                     pre_ph_d;
    wire                    tdone;

    assign tdone        = (tmr_q == 4'h0);
    assign ap_pre_phase = pre_ph_q;
    assign burst_busy   = (state_q == `SGBS_ST_READ || state_q == `SGBS_ST_WRITE)
                          && !tdone;

    // Legal same-bank commands; transient states accept nothing
    assign legal = (state_q == `SGBS_ST_IDLE && cmd == `SGBS_CMD_ACT)
        || (state_q == `SGBS_ST_ACTV &&
            (cmd == `SGBS_CMD_RD || cmd == `SGBS_CMD_WR || cmd == `SGBS_CMD_PRE))
        || (state_q == `SGBS_ST_READ &&
            (cmd == `SGBS_CMD_RD || (tdone &&
             (cmd == `SGBS_CMD_WR || cmd == `SGBS_CMD_PRE))))
        || (state_q == `SGBS_ST_WRITE &&
            (cmd == `SGBS_CMD_RD || cmd == `SGBS_CMD_WR ||
             (tdone && cmd == `SGBS_CMD_PRE)));

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        state_d  = state_q;
        tmr_d    = tdone ? 4'h0 : tmr_q - ONE;
        pre_ph_d = pre_ph_q;
        if (force_idle) begin
            state_d  = `SGBS_ST_IDLE;
            tmr_d    = 4'h0;
            pre_ph_d = 1'b0;
        end else if (hit && legal) begin
            case (cmd)
                `SGBS_CMD_ACT: begin
                    state_d = `SGBS_ST_ACTG;
                    tmr_d   = T_RCD - ONE;
                end
                `SGBS_CMD_PRE: begin
                    state_d = `SGBS_ST_PRE;
                    tmr_d   = T_RP - ONE;
                end
                `SGBS_CMD_RD: begin
                    state_d = auto_pre ? `SGBS_ST_RDAP : `SGBS_ST_READ;
                    tmr_d   = T_BURST - ONE;
                end
                `SGBS_CMD_WR: begin
                    state_d = auto_pre ? `SGBS_ST_WRAP : `SGBS_ST_WRITE;
                    tmr_d   = auto_pre ? T_BURST + T_WR - ONE : T_BURST - ONE;
                end
                default: state_d = state_q;
            endcase
            pre_ph_d = 1'b0;
        end else if (tdone) begin
            case (state_q)
                `SGBS_ST_ACTG: state_d = `SGBS_ST_ACTV;
                `SGBS_ST_PRE:  state_d = `SGBS_ST_IDLE;
                // Burst over: the row stays open for the next access
                `SGBS_ST_READ, `SGBS_ST_WRITE: state_d = `SGBS_ST_ACTV;
                `SGBS_ST_RDAP, `SGBS_ST_WRAP: begin
                    // Access period over: start the precharge period
                    if (!pre_ph_q) begin
                        pre_ph_d = 1'b1;
                        tmr_d    = T_RP - ONE;
                    end else begin
                        pre_ph_d = 1'b0;
                        state_d  = `SGBS_ST_IDLE;
                    end
                end
                default: state_d = state_q;
            endcase
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= `SGBS_ST_IDLE;
            tmr_q    <= 4'h0;
            pre_ph_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            tmr_q    <= tmr_d;
            pre_ph_q <= pre_ph_d;
        end
    end
endmodule

// File: core/sgbs_bank_tracker.v
// Function
// - Tables valid only with enable held low
// - Chip-select high or all-high is idle
// - Decode active, read, write, precharge strobes
// - Idle once precharged and row precharge done
// - Row active after row-to-column delay
// - Precharge command enters precharging, then idle
// - Activate enters activating, then row active
// - Read auto-precharge state ends idle
// - Write auto-precharge state ends idle
// - Refresh holds until refresh cycle ends
// - Mode register set holds for delay
// - Precharge all holds for precharge time
// - Access tracked until last burst nibble
// - Reads and writes include auto-precharge forms
// - Idle bank allows other-bank commands
// - Busy bank allows other-bank bank commands
// - Writes cover all three mask variants
// - Auto-precharge splits into access, precharge
// - Write precharge period starts after recovery
`timescale 1ns/1ns
`include "sgbs_defines.vh"

module sgbs_bank_tracker #(
    parameter       BANKS   = 16,
    parameter       BA_W    = 4,
    parameter [3:0] T_RP    = `SGBS_T_RP,
    parameter [3:0] T_RCD   = `SGBS_T_RCD,
    parameter [5:0] T_RC    = `SGBS_T_RC,
    parameter [3:0] T_MRD   = `SGBS_T_MRD,
    parameter [3:0] T_WR    = `SGBS_T_WR,
    parameter [3:0] T_BURST = `SGBS_T_BURST
) (
    input  wire                          core_clk,
    input  wire                          arst_n,
    input  wire                          cs_n,
    input  wire                          ras_n,
    input  wire                          cas_n,
    input  wire                          we_n,
    input  wire                          cke_n,
    input  wire                          xs_done,
    input  wire [BA_W-1:0]               bank_addr,
    input  wire                          auto_pre,
    input  wire                          pre_all,
    input  wire [1:0]                    write_mask_kind,
    output reg  [`SGBS_DV_W-1:0]         dev_state_q,
    output wire [BANKS*`SGBS_ST_W-1:0]   bank_states,
    output wire                          all_idle,
    output reg                           cmd_illegal_q,
    output reg  [`SGBS_CMD_W-1:0]        last_cmd_q,
    output reg  [1:0]                    last_wmask_q
);
    localparam [5:0] ONE6 = 6'h01;

    // ----------------------------------------
    // Clock enable history and decode
    // ----------------------------------------
    reg                        cke_n_prev_q;
    wire [`SGBS_CMD_W-1:0]     cmd;
    wire                       tables_on;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cke_n_prev_q <= 1'b1;
        end else begin
            cke_n_prev_q <= cke_n;
        end
    end

    sgbs_cmd_decode u_dec (
        .cs_n       (cs_n),
        .ras_n      (ras_n),
        .cas_n      (cas_n),
        .we_n       (we_n),
        .cke_n      (cke_n),
        .cke_n_prev (cke_n_prev_q),
        .xs_done    (xs_done),
        .cmd        (cmd),
        .tables_on  (tables_on)
    );

    // ----------------------------------------
    // Device-wide gating
    // ----------------------------------------
    wire         dev_norm;
    wire         bank_cmd;
    wire         is_pall;
    wire [BANKS-1:0] idle_vec;
    wire [BANKS-1:0] legal_vec;
    wire [BANKS-1:0] busy_vec;
    wire [BANKS-1:0] pre_ok_vec;
    wire         any_burst;
    wire         pall_ok;
    wire         dev_cmd_ok;
    reg  [5:0]   dtmr_q;
    reg  [5:0]   dtmr_d;
    reg  [`SGBS_DV_W-1:0] dev_state_d;
    wire         dev_done;
    wire         force_idle;
    wire         sel_legal;

    assign dev_norm   = (dev_state_q == `SGBS_DV_NORM);
    assign bank_cmd   = (cmd == `SGBS_CMD_ACT || cmd == `SGBS_CMD_RD ||
                         cmd == `SGBS_CMD_WR || cmd == `SGBS_CMD_PRE);
    assign is_pall    = (cmd == `SGBS_CMD_PRE) && pre_all;
    assign all_idle   = &idle_vec;
    assign any_burst  = |busy_vec;
    // Refresh and mode register set only from all idle, nothing bursting
    assign dev_cmd_ok = all_idle && !any_burst;
    // Precharge all needs every bank in a state that may precharge
    assign pall_ok    = &pre_ok_vec;
    assign dev_done   = (dtmr_q == 6'h00);
    assign force_idle = !dev_norm && dev_done;
    // Other banks are not consulted: bank-interleaved commands are free
    assign sel_legal  = legal_vec[bank_addr];

    // ----------------------------------------
    // Per-bank state machines
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi = gi + 1) begin : g_bank
            wire hit;
            wire [`SGBS_ST_W-1:0] st;
            assign hit = tables_on && dev_norm && !is_pall && bank_cmd &&
                         (bank_addr == gi[BA_W-1:0]);
            assign idle_vec[gi]   = (st == `SGBS_ST_IDLE);
            assign pre_ok_vec[gi] = (st == `SGBS_ST_IDLE) || (st == `SGBS_ST_ACTV) ||
                                    ((st == `SGBS_ST_READ || st == `SGBS_ST_WRITE) &&
                                     !busy_vec[gi]);
            assign bank_states[gi*`SGBS_ST_W +: `SGBS_ST_W] = st;
            sgbs_bank #(
                .T_RP    (T_RP),
                .T_RCD   (T_RCD),
                .T_WR    (T_WR),
                .T_BURST (T_BURST)
            ) u_bank (
                .core_clk     (core_clk),
                .arst_n       (arst_n),
                .hit          (hit),
                .cmd          (cmd),
                .auto_pre     (auto_pre),
                .force_idle   (force_idle),
                .state_q      (st),
                .legal        (legal_vec[gi]),
                .ap_pre_phase (),
                .burst_busy   (busy_vec[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Device-wide state machine
    // ----------------------------------------
    always @* begin
        dev_state_d = dev_state_q;
        dtmr_d      = dev_done ? 6'h00 : dtmr_q - ONE6;
        case (dev_state_q)
            `SGBS_DV_NORM: begin
                if (tables_on && dev_cmd_ok && cmd == `SGBS_CMD_REF) begin
                    dev_state_d = `SGBS_DV_REF;
                    dtmr_d      = T_RC - ONE6;
                end else if (tables_on && dev_cmd_ok && cmd == `SGBS_CMD_MRS) begin
                    dev_state_d = `SGBS_DV_MRS;
                    dtmr_d      = {2'b00, T_MRD} - ONE6;
                end else if (tables_on && is_pall && pall_ok) begin
                    dev_state_d = `SGBS_DV_PALL;
                    dtmr_d      = {2'b00, T_RP} - ONE6;
                end
            end
            // Nothing is accepted until the device-wide wait ends
            `SGBS_DV_REF, `SGBS_DV_MRS, `SGBS_DV_PALL: begin
                if (dev_done) begin
                    dev_state_d = `SGBS_DV_NORM;
                end
            end
            default: dev_state_d = `SGBS_DV_NORM;
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_state_q <= `SGBS_DV_NORM;
            dtmr_q      <= 6'h00;
        end else begin
            dev_state_q <= dev_state_d;
            dtmr_q      <= dtmr_d;
        end
    end

    // ----------------------------------------
    // Command flags: illegal strobe and last accepted
    // ----------------------------------------
    wire bad_bank;
    wire bad_dev;
    wire bad_busy;
    assign bad_bank = bank_cmd && !is_pall && !sel_legal;
    assign bad_dev  = ((cmd == `SGBS_CMD_REF || cmd == `SGBS_CMD_MRS) && !dev_cmd_ok) ||
                      (is_pall && !pall_ok) || (cmd == `SGBS_CMD_RSV);
    assign bad_busy = !dev_norm && cmd != `SGBS_CMD_DESEL && cmd != `SGBS_CMD_NOP;

    // Flag is one cycle per offending edge; no state moves on it
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_illegal_q <= 1'b0;
            last_cmd_q    <= `SGBS_CMD_DESEL;
            last_wmask_q  <= `SGBS_WM_NONE;
        end else begin
            cmd_illegal_q <= tables_on && (bad_busy || (dev_norm && (bad_bank || bad_dev)));
            if (tables_on && dev_norm && cmd != `SGBS_CMD_DESEL && cmd != `SGBS_CMD_NOP
                && !bad_bank && !bad_dev) begin
                last_cmd_q <= cmd;
                if (cmd == `SGBS_CMD_WR) begin
                    last_wmask_q <= write_mask_kind;
                end
            end
        end
    end
endmodule

// File: tb/sgbs_bank_tracker_asserts.sv
`timescale 1ns/1ns
module sgbs_tracker_chk #(
    parameter [5:0] T_RC = 6'h10
) (
    input logic         core_clk,
    input logic         arst_n,
    input logic         cs_n,
    input logic         ras_n,
    input logic         cas_n,
    input logic         we_n,
    input logic         cke_n,
    input logic         xs_done,
    input logic [3:0]   bank_addr,
    input logic         auto_pre,
    input logic         pre_all,
    input logic [3:0]   dev_state_q,
    input logic [127:0] bank_states,
    input logic         all_idle,
    input logic         cmd_illegal_q
);
    // ----------------------------------------
    // Decode helpers, bank 0 is the watched one
    // ----------------------------------------
    logic       cke_n_q;
    logic [5:0] ref_cnt_q;
    wire        ok   = !cs_n && !cke_n && !cke_n_q && xs_done;
    wire        nrm  = ok && dev_state_q == 4'h1;
    wire        act  = nrm && !ras_n && cas_n && we_n;
    wire        rd   = nrm && ras_n && !cas_n && we_n;
    wire        wr   = nrm && ras_n && !cas_n && !we_n;
    wire        pre  = nrm && !ras_n && cas_n && !we_n;
    wire        refr = nrm && !ras_n && !cas_n && we_n;
    wire        mrs  = nrm && !ras_n && !cas_n && !we_n;
    wire        b0   = bank_addr == 4'h0;
    wire [7:0]  s0   = bank_states[7:0];
    // Precharge all is only checked with every bank idle or row active
    wire        pall_ok = ~|(bank_states & {16{8'hfa}});

    // Enable history and refresh length; counting avoids a long repetition
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cke_n_q   <= 1'b1;
            ref_cnt_q <= 6'h00;
        end else begin
            cke_n_q   <= cke_n;
            ref_cnt_q <= (dev_state_q == 4'h2) ? ref_cnt_q + 6'h01 : 6'h00;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_opening; (s0 == 8'h02) [*4] ##1 (s0 == 8'h04); endsequence
    sequence s_closing; (s0 == 8'h20) [*4] ##1 (s0 == 8'h01); endsequence
    sequence s_wr_access; (s0 == 8'h80) [*6]; endsequence
    sequence s_wr_pre; (s0 == 8'h80) [*4] ##1 (s0 == 8'h01); endsequence

    a_act_open: assert property (act && b0 && s0 == 8'h01 |=> s_opening)
        else $error("bank activation timing wrong");
    a_pre_close: assert property (pre && b0 && !pre_all && s0 == 8'h04 |=> s_closing)
        else $error("bank precharge timing wrong");
    a_rd_burst: assert property (rd && b0 && !auto_pre && s0 == 8'h04
        |=> (s0 == 8'h08) [*2] ##1 (s0 == 8'h04)) else $error("read burst timing wrong");
    a_rdap_idle: assert property (rd && b0 && auto_pre && s0 == 8'h04
        |=> (s0 == 8'h40) [*6] ##1 (s0 == 8'h01)) else $error("read autoprecharge wrong");
    a_wrap_idle: assert property (wr && b0 && auto_pre && s0 == 8'h04
        |=> s_wr_access ##1 s_wr_pre) else $error("write autoprecharge wrong");
    a_bad_refused: assert property (nrm && b0 && s0 == 8'h02 && (rd || wr)
        |=> cmd_illegal_q ##1 !cmd_illegal_q) else $error("busy bank took a command");
    a_desel_quiet: assert property (cs_n && dev_state_q == 4'h1 && s0 == 8'h01
        |=> s0 == 8'h01 && !cmd_illegal_q) else $error("deselect changed state");
    a_cke_gate: assert property ((cke_n || !xs_done) && dev_state_q == 4'h1 && s0 == 8'h01
        |=> s0 == 8'h01 && !cmd_illegal_q) else $error("gated command acted");
    a_wide_busy: assert property (ok && dev_state_q != 4'h1 && !(ras_n && cas_n && we_n)
        |=> cmd_illegal_q) else $error("command taken in device-wide state");
    a_ref_start: assert property (refr && all_idle |=> dev_state_q == 4'h2)
        else $error("refresh not started");
    a_ref_len: assert property ($fell(dev_state_q == 4'h2) |-> ref_cnt_q == T_RC)
        else $error("refresh length wrong");
    a_mrs_len: assert property (mrs && all_idle
        |=> (dev_state_q == 4'h4) [*4] ##1 (dev_state_q == 4'h1)) else $error("mode set wrong");
    a_pall_all: assert property (pre && pre_all && pall_ok
        |=> (dev_state_q == 4'h8) [*4] ##1 (dev_state_q == 4'h1 && all_idle))
        else $error("precharge all wrong");
endmodule

// File: tb/sgbs_ctrl_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Memory controller model
// ----------------------------------------
module sgbs_ctrl_model (
    input  wire       core_clk,
    output reg        cs_n,
    output reg        ras_n,
    output reg        cas_n,
    output reg        we_n,
    output reg  [3:0] bank_addr,
    output reg        auto_pre,
    output reg        pre_all,
    output reg  [1:0] write_mask_kind
);
    // Start deselected with all strobes high
    initial {cs_n, ras_n, cas_n, we_n, bank_addr, auto_pre, pre_all, write_mask_kind} = 12'hfff;

    // One command per edge, held until the next edge; a deselected bank field is
    // flipped so a stale address never passes for a real one
    task issue(input logic sel_n, input logic [2:0] rcw, input logic [3:0] b,
               input logic ap, input logic pa, input logic [1:0] wm);
        @(posedge core_clk);
        cs_n            <= sel_n;
        {ras_n, cas_n, we_n} <= rcw;
        bank_addr       <= sel_n ? ~bank_addr : b;
        auto_pre        <= ap;
        pre_all         <= pa;
        write_mask_kind <= wm;
    endtask
endmodule

// File: tb/test_sgbs_bank_tracker.sv
`timescale 1ns/1ns
module test_sgbs_bank_tracker;
    typedef struct {int cyc; int what; logic [7:0] exp;} sgbs_note_t;
    logic         core_clk = 1'b0;
    logic         arst_n   = 1'b0;
    logic         cke_n    = 1'b1;
    logic         xs_done  = 1'b1;
    logic         cs_n, ras_n, cas_n, we_n, auto_pre, pre_all, all_idle, cmd_illegal_q;
    logic [3:0]   bank_addr, dev_state_q, last_cmd_q;
    logic [1:0]   write_mask_kind, last_wmask_q;
    logic [127:0] bank_states;
    logic [16:0]  lfsr_q = 17'h12083;
    int           cyc = 0, t0 = 0, err_count = 0, num_checks = 0;
    sgbs_note_t   notes[$];

    sgbs_ctrl_model i_ctrl (.core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_addr(bank_addr), .auto_pre(auto_pre), .pre_all(pre_all),
        .write_mask_kind(write_mask_kind));
    sgbs_bank_tracker i_dut (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .cke_n(cke_n), .xs_done(xs_done), .bank_addr(bank_addr),
        .auto_pre(auto_pre), .pre_all(pre_all), .write_mask_kind(write_mask_kind),
        .dev_state_q(dev_state_q), .bank_states(bank_states), .all_idle(all_idle),
        .cmd_illegal_q(cmd_illegal_q), .last_cmd_q(last_cmd_q), .last_wmask_q(last_wmask_q));

    // ----------------------------------------
    // Clock, cycle count and hang guard
    // ----------------------------------------
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            give_verdict;
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] pick(input int w);
        if (w < 16) return bank_states[w*8 +: 8];
        case (w)
            16: return {4'h0, dev_state_q};
            17: return {7'h0, cmd_illegal_q};
            18: return {4'h0, last_cmd_q};
            20: return {7'h0, all_idle};
            default: return {6'h0, last_wmask_q};
        endcase
    endfunction

    // Watcher: every note falling due this cycle is compared, then dropped
    always @(negedge core_clk) begin
        for (int i = notes.size() - 1; i >= 0; i--) begin
            if (notes[i].cyc == cyc) begin
                check($sformatf("item%0d", notes[i].what), pick(notes[i].what), notes[i].exp);
                notes.delete(i);
            end
        end
    end

    task note(input int d, input int w, input logic [7:0] v);
        notes.push_back('{t0 + d, w, v});
    endtask

    // Offsets count from the cycle right after the registering edge
    task send(input logic [2:0] rcw, input logic [3:0] b, input logic ap, input logic pa,
              input logic [1:0] wm);
        i_ctrl.issue(1'b0, rcw, b, ap, pa, wm);
        @(negedge core_clk);
        t0 = cyc + 1;
    endtask

    // Maximal-length step of the stimulus generator
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    // Random deselects and no-ops; nothing reaches a busy bank
    task idle(input int n);
        repeat (n) begin
            lfsr_q = lfsr_next(lfsr_q);
            i_ctrl.issue(lfsr_q[0], lfsr_q[0] ? lfsr_q[3:1] : 3'b111, lfsr_q[7:4],
                         lfsr_q[8], lfsr_q[9], {1'b0, lfsr_q[10]});
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        cke_n  <= 1'b0;
        @(negedge core_clk);
        t0 = cyc + 1;
        for (int b = 0; b < 16; b++) note(0, b, 8'h01);
        note(0, 16, 8'h01); note(0, 17, 8'h00); note(0, 18, 8'h00); note(0, 20, 8'h01);
        idle(3);
        send(3'b011, 4'h0, 0, 0, 0); note(3, 0, 8'h02); note(0, 18, 8'h02);
        send(3'b011, 4'h9, 0, 0, 0); note(0, 9, 8'h02); note(4, 9, 8'h04);
        send(3'b101, 4'h0, 0, 0, 0); note(0, 17, 8'h01); note(1, 17, 8'h00);
        note(0, 18, 8'h02); note(2, 0, 8'h04);
        idle(4);
        $display("test activate done");
        send(3'b110, 4'h0, 0, 0, 0); note(0, 17, 8'h01); note(0, 0, 8'h04);
        send(3'b101, 4'h0, 0, 0, 0); note(1, 0, 8'h08); note(2, 0, 8'h04);
        send(3'b100, 4'h0, 0, 0, 0); note(0, 17, 8'h01);
        idle(1);
        for (int k = 0; k < 3; k++) begin
            send(3'b100, 4'h0, 0, 0, k[1:0]); note(0, 0, 8'h10); note(0, 19, k[7:0]);
            idle(2);
        end
        send(3'b010, 4'h0, 0, 0, 0); note(3, 0, 8'h20); note(4, 0, 8'h01);
        idle(5);
        send(3'b011, 4'h0, 0, 0, 0);
        idle(4);
        send(3'b101, 4'h0, 1, 0, 0); note(5, 0, 8'h40); note(6, 0, 8'h01);
        send(3'b010, 4'h9, 0, 0, 0); note(0, 9, 8'h20); note(4, 9, 8'h01);
        idle(7);
        send(3'b011, 4'h0, 0, 0, 0);
        idle(4);
        send(3'b100, 4'h0, 1, 0, 2'h2); note(9, 0, 8'h80); note(10, 0, 8'h01);
        idle(11);
        $display("test access done");
        send(3'b011, 4'h3, 0, 0, 0); note(0, 20, 8'h00);
        idle(4);
        send(3'b001, 4'h0, 0, 0, 0); note(0, 17, 8'h01); note(0, 16, 8'h01);
        send(3'b010, 4'h0, 0, 1, 0); note(3, 16, 8'h08); note(4, 3, 8'h01);
        send(3'b011, 4'h5, 0, 0, 0); note(0, 17, 8'h01); note(3, 16, 8'h01);
        idle(4);
        send(3'b001, 4'h0, 0, 0, 0); note(15, 16, 8'h02); note(16, 16, 8'h01);
        idle(17);
        send(3'b000, 4'h0, 0, 0, 0); note(3, 16, 8'h04); note(4, 16, 8'h01);
        idle(5);
        $display("test device-wide done");
        // Enable changes ride on an idle edge so no held command is presented again
        cke_n <= 1'b1;
        send(3'b011, 4'h0, 0, 0, 0); note(0, 0, 8'h01); note(0, 18, 8'h07);
        idle(1);
        cke_n   <= 1'b0;
        xs_done <= 1'b0;
        send(3'b011, 4'h0, 0, 0, 0); note(0, 0, 8'h01); note(0, 17, 8'h00);
        idle(1);
        xs_done <= 1'b1;
        idle(1);
        send(3'b011, 4'h0, 0, 0, 0); note(0, 0, 8'h02);
        idle(6);
        $display("test enable done");
        give_verdict;
    end
endmodule

bind sgbs_bank_tracker sgbs_tracker_chk #(.T_RC(T_RC)) i_chk (.core_clk(core_clk),
    .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke_n(cke_n),
    .xs_done(xs_done), .bank_addr(bank_addr), .auto_pre(auto_pre), .pre_all(pre_all),
    .dev_state_q(dev_state_q), .bank_states(bank_states), .all_idle(all_idle),
    .cmd_illegal_q(cmd_illegal_q));
